// *** core/uam_pkg.sv ***
// How it works
// - while a frame is in flight the block asks to keep its clock running.
// - auto-baud modes flag a break after more than 11 low bit times.
// - lin auto-baud needs sync 0x55, else flag mismatch and keep baud.
// - after a break, count from the sync start bit over 8 bit times.
// - counter upper 10 bits are the divider, lower 6 bits the fraction.
// - lin baud register is written only once the whole sync field is valid.
// - generic auto-baud skips the 0x55 check, updates only within 0x0064-0xfff.
// - with wait-for-break set, a falling then rising edge counts as break.
// - one-wire mode feeds the transmit line straight into the receiver.
// - control register two bit enables multiprocessor address filtering.
// - frame type is first stop bit, or ninth bit in nine-bit frames.
// - frame type one means address frame, zero means data frame.
// - while filtering, data frames are dropped and address frames kept.
// - comm mode 0x2 switches on the infrared codec and routes the line.
// - infrared pins carry the inverse of the pulses.
// - infrared transmit pulse is 3/16 bit, fixed clock count, or none.
// - received pulses shorter than the minimum width decode as one.
// - infrared event input bit takes the event as receive source.
// - double speed is off in infrared mode, limited to 115.2kbps.
// - three requests: receive group, buffer empty, transmit done.
// - transmit done rises only when the shifter is empty and the buffer is empty or transmit is off.
// - a request stands while enable and flag are set until cleared.
package uam_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_RXDATA_LO  = 4'h0;
  localparam logic [3:0] IDX_RXDATA_HI  = 4'h1;
  localparam logic [3:0] IDX_TXDATA_LO  = 4'h2;
  localparam logic [3:0] IDX_TXDATA_HI  = 4'h3;
  localparam logic [3:0] IDX_STATUS     = 4'h4;
  localparam logic [3:0] IDX_CTRL_FIRST = 4'h5;
  localparam logic [3:0] IDX_CTRL_SECOND= 4'h6;
  localparam logic [3:0] IDX_CTRL_THIRD = 4'h7;
  localparam logic [3:0] IDX_BAUD_LO    = 4'h8;
  localparam logic [3:0] IDX_BAUD_HI    = 4'h9;
  localparam logic [3:0] IDX_EVENT_CTRL = 4'hc;
  localparam logic [3:0] IDX_TX_PULSE   = 4'hd;
  localparam logic [3:0] IDX_RX_PULSE   = 4'he;
  // status fields
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_DRE = 5;
  localparam int ST_RXS = 4;
  localparam int ST_ISF = 3;
  localparam int ST_BDF = 1;
  localparam int ST_WFB = 0;
  // first control register fields
  localparam int CA_RXC_IE = 7;
  localparam int CA_TXC_IE = 6;
  localparam int CA_DRE_IE = 5;
  localparam int CA_RXS_IE = 4;
  localparam int CA_LOOP   = 3;
  localparam int CA_ABE_IE = 2;
  // second control register fields
  localparam int CB_RXEN  = 7;
  localparam int CB_TXEN  = 6;
  localparam int CB_SFDEN = 4;
  localparam int CB_MODE_HI = 2;
  localparam int CB_MODE_LO = 1;
  localparam int CB_MPCM  = 0;
  // third control register fields
  localparam int CC_COMM_MODE_SELECT_HI = 7;
  localparam int CC_COMM_MODE_SELECT_LO = 6;
  localparam int CC_TWO_STOP = 3;
  localparam int CC_SIZE_HI  = 2;
  localparam int CC_SIZE_LO  = 0;
  // field codes and reset values
  localparam logic [1:0] RECEIVE_MODE_SELECT_NORMAL = 2'h0;
  localparam logic [1:0] RECEIVE_MODE_SELECT_2X     = 2'h1;
  localparam logic [1:0] RECEIVE_MODE_SELECT_GEN    = 2'h2;
  localparam logic [1:0] RECEIVE_MODE_SELECT_LIN    = 2'h3;
  localparam logic [1:0] COMM_MODE_SELECT_IR      = 2'h2;
  localparam logic [2:0] SIZE_NINE     = 3'h7;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;
  localparam logic [7:0] TXPL_3_16     = 8'h00;
  localparam logic [7:0] TXPL_NOMOD    = 8'hff;
  // timing counts in oversample ticks or clocks
  localparam logic [4:0] OS_1X         = 5'h10;
  localparam logic [4:0] OS_2X         = 5'h08;
  localparam int         BREAK_BITS    = 11;
  localparam logic [7:0] BREAK_TICKS   = 8'(BREAK_BITS * 16 + 1);
  localparam logic [2:0] SYNC_FALLS    = 3'h5;
  localparam logic [15:0] SYNC_STEP    = 16'h0008;
  localparam logic [15:0] AUTOBAUD_MIN = 16'h0064;
  localparam logic [15:0] AUTOBAUD_MAX = 16'h0fff;
  localparam logic [7:0] SYNC_CHAR     = 8'h55;
  localparam logic [3:0] IR_SHORT_TICKS= 4'h3;
  localparam logic [4:0] IR_HOLD_TICKS = 5'h10;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uam_rx_state_t;
  typedef enum logic [0:0] {TX_IDLE, TX_BUSY} uam_tx_state_t;

  function automatic logic [3:0] uam_char_bits(input logic [2:0] size);
    return (size == SIZE_NINE) ? 4'h9 : ((size > 3'h3) ? 4'h8 : 4'(size) + 4'h5);
  endfunction
endpackage

// *** core/uam_ir_if.sv ***
interface uam_ir_if;
  logic       tick;
  logic       tx_bit;
  logic       tx_bit_start;
  logic [3:0] tx_phase;
  logic [7:0] tx_width;
  logic [6:0] rx_min;
  logic       rx_in;
  logic       tx_pin;
  logic       rx_bit;
  modport uart  (output tick, tx_bit, tx_bit_start, tx_phase, tx_width, rx_min, rx_in,
                 input tx_pin, rx_bit);
  modport codec (input tick, tx_bit, tx_bit_start, tx_phase, tx_width, rx_min, rx_in,
                 output tx_pin, rx_bit);
endinterface

// *** core/uam_infrared_codec.sv ***
module uam_infrared_codec (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // uart side
  uam_ir_if.codec  ir
);
  import uam_pkg::*;

  typedef struct packed {
    logic       pin;
    logic [7:0] fix_cnt;
    logic [6:0] width;
    logic [4:0] hold;
  } uam_ir_state_t;

  uam_ir_state_t s;
  uam_ir_state_t n;
  logic          pulse;
  logic          pulse_in;

  always_comb begin
    n = s;
    pulse = 1'b0;
    pulse_in = ~ir.rx_in;
    if (clk_en) begin
      if (ir.tx_bit_start) begin
        n.fix_cnt = ir.tx_bit ? 8'h00 : ir.tx_width;
      end else if (s.fix_cnt != 8'h00) begin
        n.fix_cnt = s.fix_cnt - 8'h01;
      end
      // pulse shape by width setting
      if (ir.tx_width == TXPL_NOMOD) begin
        pulse = ~ir.tx_bit;
      end else if (ir.tx_width == TXPL_3_16) begin
        pulse = ~ir.tx_bit && (ir.tx_phase < IR_SHORT_TICKS);
      end else begin
        pulse = (s.fix_cnt != 8'h00);
      end
      n.pin = ~pulse;
      if (pulse_in) begin
        n.width = (s.width == 7'h7f) ? s.width : s.width + 7'h01;
      end else begin
        n.width = 7'h00;
      end
      // qualified pulse decodes as a zero bit
      if (pulse_in && ({1'b0, s.width} + 8'h01 >= {1'b0, ir.rx_min})) begin
        n.hold = IR_HOLD_TICKS;
      end else if (ir.tick && s.hold != 5'h00) begin
        n.hold = s.hold - 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s     <= '0;
      s.pin <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ir.tx_pin = s.pin;
  assign ir.rx_bit = (s.hold == 5'h00);
endmodule

// *** core/uam_top.sv ***
module uam_top (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxd_pin,
  input  wire logic        ir_event_in,
  output logic             txd_pin,
  // interrupt requests
  output logic             rx_irq,
  output logic             dre_irq,
  output logic             txc_irq,
  // power
  output logic             clock_hold
);
  import uam_pkg::*;

  typedef struct packed {
    logic [7:0]    ctrl_first;
    logic [7:0]    ctrl_second;
    logic [7:0]    ctrl_third;
    logic [15:0]   baud;
    logic          ir_event_sel;
    logic [7:0]    txpl;
    logic [6:0]    rxpl;
    logic          receive_complete_vector;
    logic          transmit_done_vector;
    logic          rxs;
    logic          isf;
    logic          bdf;
    logic          wait_break_flag;
    logic          bufovf;
    logic          ferr;
    logic [8:0]    rx_data;
    logic          tx_bit8;
    logic [8:0]    tx_buf;
    logic          tx_full;
    logic [15:0]   acc;
    logic          rxd_meta;
    logic          rxd_sync;
    logic          rx_prev;
    uam_rx_state_t rx_st;
    logic [3:0]    rx_os;
    logic [3:0]    rx_bit_i;
    logic [8:0]    rx_sh;
    logic [7:0]    low_cnt;
    logic          wfb_fell;
    logic          brk_seen;
    logic          sync_on;
    logic [2:0]    sync_falls;
    logic [15:0]   sync_cnt;
    uam_tx_state_t tx_st;
    logic [3:0]    tx_os;
    logic [3:0]    tx_left;
    logic [11:0]   tx_sh;
    logic          tx_line;
    logic          tx_bit_start;
    logic          armed;
    logic [31:0]   prdata;
  } uam_state_t;

  uam_state_t  s;
  uam_state_t  n;
  uam_ir_if    irb();
  logic        ir_on;
  logic        two_x;
  logic        autob;
  logic [1:0]  receive_mode_select;
  logic [4:0]  tpb;
  logic [3:0]  last_os;
  logic [3:0]  nbits;
  logic [16:0] step;
  logic [16:0] acc_sum;
  logic        tick;
  logic        line;
  logic        fell;
  logic        rose;
  logic        xfer;
  logic [3:0]  idx;
  logic        addr_ok;
  logic [7:0]  rd_data;
  logic [7:0]  st_byte;
  logic        frame_done;
  logic        stop_bit;
  logic [8:0]  data9;
  logic        ftype;
  logic        good;
  logic        brk;

  // start a frame from the transmit buffer
  function automatic uam_state_t tx_load(input uam_state_t st, input logic [3:0] nb);
    uam_state_t r;
    r              = st;
    r.tx_sh        = ({12{1'b1}} << nb) | {3'h0, st.tx_buf};
    r.tx_left      = nb + (st.ctrl_third[CC_TWO_STOP] ? 4'h2 : 4'h1);
    r.tx_line      = 1'b0;
    r.tx_os        = 4'h0;
    r.tx_full      = 1'b0;
    r.tx_bit_start = 1'b1;
    r.tx_st        = TX_BUSY;
    return r;
  endfunction

  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) &&
                   (idx <= IDX_BAUD_HI || (idx >= IDX_EVENT_CTRL && idx <= IDX_RX_PULSE));
  assign pready  = clk_en && s.armed;
  assign xfer    = psel && penable && pready;
  assign pslverr = xfer && !addr_ok;
  assign prdata  = s.prdata;

  always_comb begin
    st_byte         = 8'h00;
    st_byte[ST_RXC] = s.receive_complete_vector;
    st_byte[ST_TXC] = s.transmit_done_vector;
    st_byte[ST_DRE] = ~s.tx_full;
    st_byte[ST_RXS] = s.rxs;
    st_byte[ST_ISF] = s.isf;
    st_byte[ST_BDF] = s.bdf;
    st_byte[ST_WFB] = s.wait_break_flag;
    case (idx)
      IDX_RXDATA_LO:   rd_data = s.rx_data[7:0];
      IDX_RXDATA_HI:   rd_data = {s.receive_complete_vector, s.bufovf, 3'h0, s.ferr, 1'b0, s.rx_data[8]};
      IDX_TXDATA_LO:   rd_data = s.tx_buf[7:0];
      IDX_TXDATA_HI:   rd_data = {7'h00, s.tx_bit8};
      IDX_STATUS:      rd_data = st_byte;
      IDX_CTRL_FIRST:  rd_data = s.ctrl_first;
      IDX_CTRL_SECOND: rd_data = s.ctrl_second;
      IDX_CTRL_THIRD:  rd_data = s.ctrl_third;
      IDX_BAUD_LO:     rd_data = s.baud[7:0];
      IDX_BAUD_HI:     rd_data = s.baud[15:8];
      IDX_EVENT_CTRL:  rd_data = {7'h00, s.ir_event_sel};
      IDX_TX_PULSE:    rd_data = s.txpl;
      IDX_RX_PULSE:    rd_data = {1'b0, s.rxpl};
      default:         rd_data = 8'h00;
    endcase
  end

  always_comb begin
    n          = s;
    receive_mode_select     = s.ctrl_second[CB_MODE_HI:CB_MODE_LO];
    ir_on      = (s.ctrl_third[CC_COMM_MODE_SELECT_HI:CC_COMM_MODE_SELECT_LO] == COMM_MODE_SELECT_IR);
    two_x      = (receive_mode_select == RECEIVE_MODE_SELECT_2X) && !ir_on;
    autob      = (receive_mode_select == RECEIVE_MODE_SELECT_GEN) || (receive_mode_select == RECEIVE_MODE_SELECT_LIN);
    tpb        = two_x ? OS_2X : OS_1X;
    last_os    = 4'(tpb - 5'h01);
    nbits      = uam_char_bits(s.ctrl_third[CC_SIZE_HI:CC_SIZE_LO]);
    step       = {6'h00, tpb, 6'h00};
    acc_sum    = {1'b0, s.acc} + step;
    tick       = 1'b0;
    frame_done = 1'b0;
    stop_bit   = 1'b1;
    good       = 1'b0;
    brk        = 1'b0;
    ftype      = 1'b0;
    data9      = s.rx_sh >> (4'h9 - nbits);
    if (s.ctrl_first[CA_LOOP]) begin
      line = s.tx_line;
    end else if (ir_on) begin
      line = irb.rx_bit;
    end else begin
      line = s.rxd_sync;
    end
    fell = s.rx_prev && !line;
    rose = !s.rx_prev && line;
    if (clk_en) begin
      n.rxd_meta     = rxd_pin;
      n.rxd_sync     = s.rxd_meta;
      n.rx_prev      = line;
      n.tx_bit_start = 1'b0;
      // fractional baud: baud is 64 times the bit period in clocks
      if (acc_sum >= {1'b0, s.baud}) begin
        tick  = 1'b1;
        n.acc = ({1'b0, s.baud} <= step) ? 16'h0000 : 16'(acc_sum - {1'b0, s.baud});
      end else begin
        n.acc = acc_sum[15:0];
      end

      // bus read capture and register writes
      n.armed = psel && !xfer;
      if (psel && !xfer) begin
        n.prdata = {24'h000000, rd_data};
      end
      if (xfer && addr_ok && !pwrite && idx == IDX_RXDATA_LO) begin
        n.receive_complete_vector    = 1'b0;
        n.bufovf = 1'b0;
        n.ferr   = 1'b0;
      end
      if (xfer && addr_ok && pwrite && pstrb[0]) begin
        case (idx)
          IDX_TXDATA_LO: begin
            if (!s.tx_full) begin
              n.tx_buf  = {s.tx_bit8, pwdata[7:0]};
              n.tx_full = 1'b1;
            end
          end
          IDX_TXDATA_HI: n.tx_bit8 = pwdata[0];
          IDX_STATUS: begin
            if (pwdata[ST_TXC]) n.transmit_done_vector = 1'b0;
            if (pwdata[ST_RXS]) n.rxs = 1'b0;
            if (pwdata[ST_ISF]) n.isf = 1'b0;
            if (pwdata[ST_BDF]) n.bdf = 1'b0;
            if (pwdata[ST_WFB]) n.wait_break_flag = 1'b1;
          end
          IDX_CTRL_FIRST:  n.ctrl_first  = pwdata[7:0];
          IDX_CTRL_SECOND: n.ctrl_second = pwdata[7:0];
          IDX_CTRL_THIRD:  n.ctrl_third  = pwdata[7:0];
          IDX_BAUD_LO:     n.baud[7:0]   = pwdata[7:0];
          IDX_BAUD_HI:     n.baud[15:8]  = pwdata[7:0];
          IDX_EVENT_CTRL:  n.ir_event_sel = pwdata[0];
          IDX_TX_PULSE:    n.txpl = pwdata[7:0];
          IDX_RX_PULSE:    n.rxpl = pwdata[6:0];
          default: ;
        endcase
      end

      // receiver
      if (!s.ctrl_second[CB_RXEN]) begin
        n.rx_st    = RX_IDLE;
        n.receive_complete_vector      = 1'b0;
        n.brk_seen = 1'b0;
        n.sync_on  = 1'b0;
      end else begin
        if (autob) begin
          if (line) begin
            n.low_cnt = 8'h00;
          end else if (tick && s.low_cnt != BREAK_TICKS) begin
            n.low_cnt = s.low_cnt + 8'h01;
            if (s.low_cnt == BREAK_TICKS - 8'h01) brk = 1'b1;
          end
        end
        if (s.wait_break_flag) begin
          if (fell) n.wfb_fell = 1'b1;
          if (rose && s.wfb_fell) begin
            brk        = 1'b1;
            n.wait_break_flag      = 1'b0;
            n.wfb_fell = 1'b0;
          end
        end
        // sync field length, eight clocks' weight per clock
        if (s.sync_on) begin
          n.sync_cnt = (s.sync_cnt > 16'hffff - SYNC_STEP) ? 16'hffff : s.sync_cnt + SYNC_STEP;
          if (fell) begin
            n.sync_falls = s.sync_falls + 3'h1;
            if (s.sync_falls == SYNC_FALLS - 3'h1) n.sync_on = 1'b0;
          end
        end
        case (s.rx_st)
          RX_IDLE: begin
            if (fell) begin
              n.rx_st = RX_START;
              n.rx_os = 4'h0;
              if (s.ctrl_second[CB_SFDEN]) n.rxs = 1'b1;
              if (s.brk_seen && s.sync_falls == 3'h0) begin
                n.sync_on    = 1'b1;
                n.sync_cnt   = 16'h0000;
                n.sync_falls = 3'h1;
              end
            end
          end
          RX_START: begin
            if (tick) begin
              if (s.rx_os == tpb[4:1]) begin
                n.rx_st    = line ? RX_IDLE : RX_DATA;
                n.rx_os    = 4'h0;
                n.rx_bit_i = 4'h0;
              end else begin
                n.rx_os = s.rx_os + 4'h1;
              end
            end
          end
          RX_DATA: begin
            if (tick) begin
              if (s.rx_os == last_os) begin
                n.rx_os    = 4'h0;
                n.rx_sh    = {line, s.rx_sh[8:1]};
                n.rx_bit_i = s.rx_bit_i + 4'h1;
                if (s.rx_bit_i == nbits - 4'h1) n.rx_st = RX_STOP;
              end else begin
                n.rx_os = s.rx_os + 4'h1;
              end
            end
          end
          RX_STOP: begin
            if (tick) begin
              if (s.rx_os == last_os) begin
                frame_done = 1'b1;
                stop_bit   = line;
                n.rx_st    = RX_IDLE;
              end else begin
                n.rx_os = s.rx_os + 4'h1;
              end
            end
          end
          default: n.rx_st = RX_IDLE;
        endcase
        if (frame_done) begin
          ftype = (nbits == 4'h9) ? data9[8] : stop_bit;
          if (s.brk_seen && receive_mode_select == RECEIVE_MODE_SELECT_LIN) begin
            good = stop_bit && !s.sync_on && (s.sync_falls == SYNC_FALLS);
            good = good && (data9[7:0] == SYNC_CHAR);
            if (good) begin
              n.baud = s.sync_cnt;
            end else begin
              n.isf = 1'b1;
            end
            n.brk_seen   = 1'b0;
            n.sync_on    = 1'b0;
            n.sync_falls = 3'h0;
          end else if (s.brk_seen) begin
            // sync char at an unknown rate is never stored
            n.rx_data = s.rx_data;
          end else if (autob && data9 == 9'h000 && !stop_bit) begin
            n.bdf = n.bdf;
          end else if (s.ctrl_second[CB_MPCM] && !ftype) begin
            n.rx_data = s.rx_data;
          end else if (s.receive_complete_vector) begin
            n.bufovf = 1'b1;
          end else begin
            n.rx_data = data9;
            n.ferr    = !stop_bit;
            n.receive_complete_vector     = 1'b1;
          end
        end
        // other modes judge the count once the sync stop bit begins
        if (receive_mode_select != RECEIVE_MODE_SELECT_LIN && s.brk_seen && !s.sync_on &&
            s.sync_falls == SYNC_FALLS && rose) begin
          if (s.sync_cnt >= AUTOBAUD_MIN && s.sync_cnt <= AUTOBAUD_MAX) begin
            n.baud = s.sync_cnt;
          end else begin
            n.isf = 1'b1;
          end
          n.brk_seen   = 1'b0;
          n.sync_falls = 3'h0;
          n.rx_st      = RX_IDLE;
        end
        if (brk) begin
          n.bdf        = 1'b1;
          n.brk_seen   = 1'b1;
          n.sync_on    = 1'b0;
          n.sync_falls = 3'h0;
          n.rx_st      = RX_IDLE;
        end
      end

      // transmitter
      case (s.tx_st)
        TX_IDLE: begin
          if (s.ctrl_second[CB_TXEN] && s.tx_full) n = tx_load(n, nbits);
        end
        TX_BUSY: begin
          if (tick) begin
            if (s.tx_os == last_os) begin
              n.tx_os = 4'h0;
              if (s.tx_left == 4'h0) begin
                if (s.ctrl_second[CB_TXEN] && s.tx_full) begin
                  n = tx_load(n, nbits);
                end else begin
                  n.tx_st = TX_IDLE;
                  n.transmit_done_vector   = 1'b1;
                end
              end else begin
                n.tx_line      = s.tx_sh[0];
                n.tx_sh        = {1'b1, s.tx_sh[11:1]};
                n.tx_left      = s.tx_left - 4'h1;
                n.tx_bit_start = 1'b1;
              end
            end else begin
              n.tx_os = s.tx_os + 4'h1;
            end
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s             <= '0;
      s.ctrl_first  <= CTRL_RESET;
      s.ctrl_second <= CTRL_RESET;
      s.ctrl_third  <= CTRL_RESET;
      s.baud        <= BAUD_RESET;
      s.rxd_meta    <= 1'b1;
      s.rxd_sync    <= 1'b1;
      s.rx_prev     <= 1'b1;
      s.tx_line     <= 1'b1;
      s.rx_st       <= RX_IDLE;
      s.tx_st       <= TX_IDLE;
    end else begin
      s <= n;
    end
  end

  assign irb.tick         = tick;
  assign irb.tx_bit       = s.tx_line;
  assign irb.tx_bit_start = s.tx_bit_start;
  assign irb.tx_phase     = s.tx_os;
  assign irb.tx_width     = s.txpl;
  assign irb.rx_min       = s.rxpl;
  assign irb.rx_in        = s.ir_event_sel ? ir_event_in : s.rxd_sync;

  uam_infrared_codec u_infrared_codec (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .ir      (irb.codec)
  );

  assign txd_pin = ir_on ? irb.tx_pin : s.tx_line;
  // three request lines
  assign rx_irq  = (s.receive_complete_vector && s.ctrl_first[CA_RXC_IE]) || (s.rxs && s.ctrl_first[CA_RXS_IE]) ||
                   (s.isf && s.ctrl_first[CA_ABE_IE]);
  assign dre_irq = !s.tx_full && s.ctrl_first[CA_DRE_IE];
  assign txc_irq = s.transmit_done_vector && s.ctrl_first[CA_TXC_IE];
  assign clock_hold = (s.rx_st != RX_IDLE) || (s.tx_st != TX_IDLE) || s.tx_full;
endmodule

// *** tb/uam_chk.sv ***
module uam_chk (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and requests
  input wire logic        txd_pin,
  input wire logic        rx_irq,
  input wire logic        txc_irq,
  input wire logic        clock_hold
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  a_pready_zero_wait: assert property (psel && !penable && clk_en ##1 penable && clk_en |-> pready)
    else $error("late pready");
  a_pready_frozen: assert property (!clk_en |-> !pready)
    else $error("pready when frozen");
  a_err_unmapped: assert property (psel && penable && paddr == 8'h28 |-> pslverr)
    else $error("no pslverr");
  a_err_mapped: assert property (psel && penable && paddr < 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false pslverr");
  a_read_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_hold_in_frame: assert property (!txd_pin |-> clock_hold)
    else $error("clock not held");
  a_irq_until_clear: assert property ($fell(rx_irq) || $fell(txc_irq) |-> $past(acc))
    else $error("request dropped");
  a_txc_after_frame: assert property ($rose(txc_irq) |-> txd_pin)
    else $error("done while sending");
  cover property ($rose(txc_irq));
  cover property ($rose(rx_irq));
  cover property (acc && pslverr);
endmodule
bind uam_top uam_chk uam_chk_inst (.*);

// *** tb/uam_remote.sv ***
module uam_remote (
  // line to the device
  input wire logic pclk,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rxd = 1'b1;
  // lsb first; released line idles high
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (per) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (per) @(posedge pclk);
  endtask
endmodule

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uam_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, rxd, txd;
  logic        rx_irq, dre_irq, txc_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          err_total, checks;
  uam_top uam_top_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(), .rxd_pin(rxd), .ir_event_in(1'b0), .txd_pin(txd),
    .rx_irq(rx_irq), .dre_irq(dre_irq), .txc_irq(txc_irq), .clock_hold()
  );
  uam_remote uam_remote_inst (.pclk(pclk), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100us;
    err_total++;
    results;
  end
  task automatic results;
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, i, d, q);
  endtask
  task automatic chk(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, i, 8'h00, q);
    cmp(q, e);
  endtask
  task automatic snd(input logic [10:0] f, input int n, input int p);
    uam_remote_inst.send(f, n, p);
  endtask
  task automatic t_regs;
    chk(IDX_STATUS, 8'h20);
    chk(4'ha, 8'h00);
    wr(IDX_CTRL_FIRST, 8'h20);
    cmp({7'h0, dre_irq}, 8'h01);
  endtask
  task automatic t_tx;
    logic [7:0] b;
    wr(IDX_CTRL_FIRST, 8'h48);
    wr(IDX_CTRL_SECOND, 8'hc0);
    wr(IDX_CTRL_THIRD, 8'h03);
    wr(IDX_TXDATA_LO, 8'ha5);
    while (txd) @(posedge pclk);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      b[i] = txd;
    end
    cmp(b, 8'ha5);
    repeat (40) @(posedge pclk);
    cmp({7'h0, txc_irq}, 8'h01);
    chk(IDX_RXDATA_LO, 8'ha5);
    wr(IDX_STATUS, 8'h40);
    cmp({7'h0, txc_irq}, 8'h00);
    wr(IDX_CTRL_FIRST, 8'h00);
  endtask
  task automatic t_mpcm;
    wr(IDX_CTRL_SECOND, 8'h81);
    wr(IDX_CTRL_THIRD, 8'h0b);
    snd(11'h422, 11, 16);
    chk(IDX_STATUS, 8'h20);
    snd(11'h644, 11, 16);
    chk(IDX_RXDATA_LO, 8'h22);
    wr(IDX_CTRL_SECOND, 8'h80);
    snd(11'h622, 11, 16);
    chk(IDX_RXDATA_LO, 8'h11);
  endtask
  task automatic t_auto;
    wr(IDX_CTRL_THIRD, 8'h03);
    wr(IDX_CTRL_FIRST, 8'h04);
    wr(IDX_CTRL_SECOND, 8'h86);
    snd(11'h000, 1, 200);
    snd(11'h2aa, 10, 16);
    chk(IDX_BAUD_LO, 8'h00);
    chk(IDX_BAUD_HI, 8'h04);
    snd(11'h000, 1, 200);
    snd(11'h2a8, 10, 16);
    chk(IDX_STATUS, 8'h2a);
    chk(IDX_BAUD_HI, 8'h04);
    cmp({7'h0, rx_irq}, 8'h01);
    wr(IDX_CTRL_SECOND, 8'h84);
    snd(11'h000, 1, 200);
    snd(11'h2aa, 10, 32);
    chk(IDX_BAUD_HI, 8'h08);
    wr(IDX_STATUS, 8'h01);
    snd(11'h000, 1, 40);
    snd(11'h2aa, 10, 16);
    chk(IDX_BAUD_HI, 8'h04);
  endtask
  task automatic t_ir;
    int lows;
    lows = 0;
    wr(IDX_CTRL_THIRD, 8'h83);
    wr(IDX_CTRL_SECOND, 8'h40);
    wr(IDX_TXDATA_LO, 8'h0f);
    repeat (200) begin
      @(posedge pclk);
      lows += !txd;
    end
    cmp(8'(lows), 8'h0f);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_tx;
    t_mpcm;
    t_auto;
    t_ir;
    results;
  end
endmodule
